// ==== cahc_top.v ====
// Arming, arming delay, hold-off and cluster statistics for a counter.
// Assumes APB master on i_sys_clk; pins are asynchronous; measurement
// results arrive from same-clock capture logic.
//
// Chosen here: the APB register port and the placing of the registers.
`default_nettype none
`include "cahc_defs.vh"

module cahc_top (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst_n,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg o_pready,
    output reg [31:0] o_prdata,
    output reg o_pslverr,
    // Signal pins
    input wire i_in_a,
    input wire i_in_b,
    input wire i_in_e,
    // Measurement path
    input wire i_meas_valid,
    input wire [15:0] i_meas_value,
    output reg o_path_b,
    output reg o_trig,
    output reg o_armed,
    output reg o_holdoff,
    output reg o_stat_valid,
    output reg [15:0] o_stat_value,
    output reg o_ref_ext
);

localparam S_IDLE = 6'b000001;
localparam S_WAIT = 6'b000010;
localparam S_DELAY = 6'b000100;
localparam S_RUN = 6'b001000;
localparam S_STAT = 6'b010000;
localparam S_NEXT = 6'b100000;

// Reset release
reg rst_meta;
reg rst_n;
always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        rst_meta <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n <= rst_meta;
    end
end

// Pins
wire [2:0] pins_s;
cahc_sync #(.W(3)) u_sync (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_async({i_in_e, i_in_b, i_in_a}),
    .o_sync(pins_s)
);

// Registers
reg [31:0] mode;
reg [23:0] arm_dly;
reg [27:0] ho_val;
reg [15:0] stat_size;
reg [31:0] blocks;
reg [5:0] state;
reg [15:0] blocks_left;
reg [15:0] meas_cnt;
reg [27:0] dly_cnt;
reg [27:0] ho_rem;
reg ho_active;
reg [15:0] result;
reg prev_a;
reg prev_b;
reg prev_arm;
reg [31:0] sum;
reg [47:0] sumsq;
reg [15:0] vmax;
reg [15:0] vmin;
reg [1:0] phase;
reg [31:0] mean_sq;
reg math_go;
reg math_sqrt;
reg [47:0] math_num;

wire shared = mode[`CAHC_MODE_SHARED];
wire [1:0] src = mode[`CAHC_MODE_SRC_LO +: 2];
wire slope_fall = mode[`CAHC_MODE_SLOPE];
wire [1:0] dly_mode = mode[`CAHC_MODE_ADLY_LO +: 2];
wire [1:0] ho_mode = mode[`CAHC_MODE_HO_LO +: 2];
wire [2:0] stat_mode = mode[`CAHC_MODE_STAT_LO +: 3];
wire stat_on = (stat_mode != `CAHC_STAT_OFF);
wire multi = mode[`CAHC_MODE_MULTI] | stat_on;

wire path_a = pins_s[0];
wire path_b = shared ? pins_s[0] : pins_s[1];
// Rear source arms from E only; B edges are counted afterwards
wire arm_sig = (src == `CAHC_SRC_REAR) ? pins_s[2] : path_b;
wire arm_edge = slope_fall ? (prev_arm & ~arm_sig) : (~prev_arm & arm_sig);
wire b_fall = prev_b & ~path_b;
wire a_rise = ~prev_a & path_a;
wire [15:0] blk_len = stat_on ? stat_size : blocks[15:0];
wire meas_last = i_meas_valid && (meas_cnt + 16'd1 >= blk_len);

// APB decode
wire apb_setup = i_psel & ~i_penable;
wire apb_wr = i_psel & i_penable & o_pready & i_pwrite;
wire cmd_wr = apb_wr && (i_paddr == `CAHC_OFS_CMD);
wire start = cmd_wr & i_pwdata[`CAHC_CMD_START];
wire stop = cmd_wr & i_pwdata[`CAHC_CMD_STOP];
reg addr_ok;
reg [31:0] rd_val;
always @* begin
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (i_paddr)
        `CAHC_OFS_MODE: rd_val = mode;
        `CAHC_OFS_ARM_DLY: rd_val = {8'h00, arm_dly};
        `CAHC_OFS_HOLDOFF: rd_val = {4'h0, ho_val};
        `CAHC_OFS_STAT_SIZE: rd_val = {16'h0000, stat_size};
        `CAHC_OFS_BLOCKS: rd_val = blocks;
        `CAHC_OFS_CMD: rd_val = 32'h0000_0000;
        `CAHC_OFS_STATUS: rd_val = {blocks_left, 9'h000, ho_active, state};
        `CAHC_OFS_RESULT: rd_val = {16'h0000, result};
        default: addr_ok = 1'b0;
    endcase
end

// Answer lands one cycle after setup
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        o_pready <= 1'b0;
        o_prdata <= 32'h0000_0000;
        o_pslverr <= 1'b0;
        mode <= `CAHC_RST_MODE;
        arm_dly <= `CAHC_RST_ARM_DLY;
        ho_val <= `CAHC_RST_HOLDOFF;
        stat_size <= `CAHC_RST_STAT_SIZE;
        blocks <= `CAHC_RST_BLOCKS;
    end else begin
        o_pready <= apb_setup;
        o_pslverr <= apb_setup & ~addr_ok;
        if (apb_setup) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : rd_val;
        end
        if (apb_wr) begin
            case (i_paddr)
                `CAHC_OFS_MODE: mode <= i_pwdata & `CAHC_MODE_MASK;
                `CAHC_OFS_ARM_DLY: arm_dly <= i_pwdata[23:0];
                `CAHC_OFS_HOLDOFF: ho_val <= i_pwdata[27:0];
                `CAHC_OFS_STAT_SIZE: stat_size <= i_pwdata[15:0];
                `CAHC_OFS_BLOCKS: blocks <= i_pwdata;
                default: ;
            endcase
        end
    end
end

// Edge history and plain outputs
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        prev_a <= 1'b0;
        prev_b <= 1'b0;
        prev_arm <= 1'b0;
        o_path_b <= 1'b0;
        o_ref_ext <= 1'b0;
    end else begin
        prev_a <= path_a;
        prev_b <= path_b;
        prev_arm <= arm_sig;
        o_path_b <= path_b;
        o_ref_ext <= mode[`CAHC_MODE_EXTREF];
    end
end

// Hold-off: triggers are measured-signal rising edges while running
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        o_trig <= 1'b0;
        ho_active <= 1'b0;
        ho_rem <= 28'h000_0000;
        o_holdoff <= 1'b0;
    end else begin
        o_trig <= 1'b0;
        o_holdoff <= ho_active;
        if (state != S_RUN) begin
            ho_active <= 1'b0;
        end else if (!ho_active) begin
            if (a_rise) begin
                o_trig <= 1'b1;
                if (ho_mode != `CAHC_DLY_OFF) begin
                    ho_active <= 1'b1;
                    ho_rem <= (ho_mode == `CAHC_DLY_COUNT) ? {4'h0, ho_val[23:0]} : ho_val;
                end
            end
        end else if (ho_mode == `CAHC_DLY_COUNT) begin
            if (b_fall) begin
                ho_rem <= ho_rem - 28'd1;
                if (ho_rem <= 28'd1) begin
                    ho_active <= 1'b0;
                end
            end
        end else begin
            // Time in 10 ns steps, several steps per clock; rounds up
            if (ho_rem <= `CAHC_HO_STEPS_PER_CYC) begin
                ho_active <= 1'b0;
            end else begin
                ho_rem <= ho_rem - `CAHC_HO_STEPS_PER_CYC;
            end
        end
    end
end

// Statistics engine
wire math_done;
wire [47:0] math_res;
cahc_math u_math (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_start(math_go),
    .i_op_sqrt(math_sqrt),
    .i_num(math_num),
    .i_den(stat_size),
    .o_done(math_done),
    .o_res(math_res)
);

wire [31:0] var_val = mean_sq - (math_res[15:0] * math_res[15:0]);
wire [31:0] sq_val = i_meas_value * i_meas_value;

// Arming sequence and cluster accumulation
always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= S_IDLE;
        blocks_left <= 16'h0000;
        meas_cnt <= 16'h0000;
        dly_cnt <= 28'h000_0000;
        o_armed <= 1'b0;
        o_stat_valid <= 1'b0;
        o_stat_value <= 16'h0000;
        result <= 16'h0000;
        sum <= 32'h0000_0000;
        sumsq <= 48'h0000_0000_0000;
        vmax <= 16'h0000;
        vmin <= 16'h0000;
        phase <= 2'h0;
        mean_sq <= 32'h0000_0000;
        math_go <= 1'b0;
        math_sqrt <= 1'b0;
        math_num <= 48'h0000_0000_0000;
    end else begin
        o_stat_valid <= 1'b0;
        math_go <= 1'b0;
        if (stop) begin
            state <= S_IDLE;
            o_armed <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        blocks_left <= multi ? blocks[31:16] : 16'h0001;
                        meas_cnt <= 16'h0000;
                        if (src == `CAHC_SRC_OFF) begin
                            state <= S_RUN;
                            o_armed <= 1'b1;
                        end else begin
                            state <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (arm_edge) begin
                        if (dly_mode == `CAHC_DLY_OFF) begin
                            state <= S_RUN;
                            o_armed <= 1'b1;
                        end else begin
                            state <= S_DELAY;
                            // Whole 100 ns steps map to exact clock counts
                            dly_cnt <= (dly_mode == `CAHC_DLY_TIME) ?
                                (arm_dly * `CAHC_ARM_CYC_PER_STEP) : {4'h0, arm_dly};
                        end
                    end
                end
                S_DELAY: begin
                    if (dly_mode == `CAHC_DLY_COUNT) begin
                        if (b_fall) begin
                            dly_cnt <= dly_cnt - 28'd1;
                            if (dly_cnt <= 28'd1) begin
                                state <= S_RUN;
                                o_armed <= 1'b1;
                            end
                        end
                    end else begin
                        dly_cnt <= dly_cnt - 28'd1;
                        if (dly_cnt <= 28'd1) begin
                            state <= S_RUN;
                            o_armed <= 1'b1;
                        end
                    end
                end
                S_RUN: begin
                    if (i_meas_valid) begin
                        meas_cnt <= meas_cnt + 16'd1;
                        if (!stat_on) begin
                            o_stat_valid <= 1'b1;
                            o_stat_value <= i_meas_value;
                        end
                        if (meas_cnt == 16'h0000) begin
                            sum <= {16'h0000, i_meas_value};
                            sumsq <= {16'h0000, sq_val};
                            vmax <= i_meas_value;
                            vmin <= i_meas_value;
                        end else begin
                            sum <= sum + {16'h0000, i_meas_value};
                            sumsq <= sumsq + {16'h0000, sq_val};
                            if (i_meas_value > vmax) begin
                                vmax <= i_meas_value;
                            end
                            if (i_meas_value < vmin) begin
                                vmin <= i_meas_value;
                            end
                        end
                        if (meas_last) begin
                            o_armed <= 1'b0;
                            state <= stat_on ? S_STAT : S_NEXT;
                            phase <= 2'h0;
                        end
                    end
                end
                S_STAT: begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: begin
                            math_go <= (stat_mode == `CAHC_STAT_MEAN) || (stat_mode == `CAHC_STAT_SPREAD);
                            math_sqrt <= 1'b0;
                            math_num <= (stat_mode == `CAHC_STAT_SPREAD) ? sumsq : {16'h0000, sum};
                            if (stat_mode == `CAHC_STAT_MAX || stat_mode == `CAHC_STAT_MIN) begin
                                o_stat_valid <= 1'b1;
                                o_stat_value <= (stat_mode == `CAHC_STAT_MAX) ? vmax : vmin;
                                result <= (stat_mode == `CAHC_STAT_MAX) ? vmax : vmin;
                                state <= S_NEXT;
                            end
                        end
                        2'h1: begin
                            phase <= 2'h1;
                            if (math_done) begin
                                phase <= 2'h2;
                                if (stat_mode == `CAHC_STAT_MEAN) begin
                                    o_stat_valid <= 1'b1;
                                    o_stat_value <= math_res[15:0];
                                    result <= math_res[15:0];
                                    state <= S_NEXT;
                                end else begin
                                    mean_sq <= math_res[31:0];
                                    math_go <= 1'b1;
                                    math_num <= {16'h0000, sum};
                                end
                            end
                        end
                        2'h2: begin
                            phase <= 2'h2;
                            if (math_done) begin
                                phase <= 2'h3;
                                math_go <= 1'b1;
                                math_sqrt <= 1'b1;
                                math_num <= {16'h0000, var_val};
                            end
                        end
                        default: begin
                            phase <= 2'h3;
                            if (math_done) begin
                                o_stat_valid <= 1'b1;
                                o_stat_value <= math_res[15:0];
                                result <= math_res[15:0];
                                state <= S_NEXT;
                            end
                        end
                    endcase
                end
                S_NEXT: begin
                    meas_cnt <= 16'h0000;
                    if (blocks_left <= 16'h0001) begin
                        state <= S_IDLE;
                        blocks_left <= 16'h0000;
                    end else begin
                        blocks_left <= blocks_left - 16'd1;
                        if (src == `CAHC_SRC_OFF) begin
                            state <= S_RUN;
                            o_armed <= 1'b1;
                        end else begin
                            state <= S_WAIT;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                    o_armed <= 1'b0;
                end
            endcase
        end
    end
end

endmodule // cahc_top
`default_nettype wire

// ==== cahc_defs.vh ====
// Constants for the counter arming and hold-off control block.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
//
// Contract
// - Shared mode feeds input A into the B path too.
// - Arming source is off, rear input E, or front input B.
// - Single block capture: one arming event starts the whole block.
// - Multiple block capture: each block waits for its own arming event.
// - Arming edge is selectable, rising or falling.
// - Arming delay is off, time, or count of B events.
// - Time delay 200 ns to 1.6 s in 100 ns steps.
// - Event count delay 2 to 16777215, 24-bit counter.
// - Delay counter always counts falling edges of B.
// - Rear arming only enables B counting; rear edges never counted.
// - Hold-off is off, time, or count of falling B events.
// - Hold-off time 50 ns to 2.68 s in 10 ns steps.
// - Hold-off count 2 to 16777215, always counted on B.
// - Statistics output: individual, mean, spread, maximum or minimum.
// - Statistics force multiple blocks; each arming starts one cluster.
// - Timebase reference selectable, internal or external.
`ifndef CAHC_DEFS_VH
`define CAHC_DEFS_VH

// Register byte offsets
`define CAHC_OFS_MODE 8'h00
`define CAHC_OFS_ARM_DLY 8'h04
`define CAHC_OFS_HOLDOFF 8'h08
`define CAHC_OFS_STAT_SIZE 8'h0C
`define CAHC_OFS_BLOCKS 8'h10
`define CAHC_OFS_CMD 8'h14
`define CAHC_OFS_STATUS 8'h18
`define CAHC_OFS_RESULT 8'h1C

// Mode register fields
`define CAHC_MODE_SHARED 0
`define CAHC_MODE_SRC_LO 1
`define CAHC_MODE_SLOPE 3
`define CAHC_MODE_ADLY_LO 4
`define CAHC_MODE_HO_LO 6
`define CAHC_MODE_STAT_LO 8
`define CAHC_MODE_MULTI 11
`define CAHC_MODE_EXTREF 12
`define CAHC_MODE_MASK 32'h0000_1FFF

// Command register fields
`define CAHC_CMD_START 0
`define CAHC_CMD_STOP 1

// Encodings
`define CAHC_SRC_OFF 2'h0
`define CAHC_SRC_REAR 2'h1
`define CAHC_SRC_FRONT 2'h2
`define CAHC_DLY_OFF 2'h0
`define CAHC_DLY_TIME 2'h1
`define CAHC_DLY_COUNT 2'h2
`define CAHC_STAT_OFF 3'h0
`define CAHC_STAT_MEAN 3'h1
`define CAHC_STAT_SPREAD 3'h2
`define CAHC_STAT_MAX 3'h3
`define CAHC_STAT_MIN 3'h4

// Reset values
`define CAHC_RST_MODE 32'h0000_0000
`define CAHC_RST_ARM_DLY 24'h00_0002
`define CAHC_RST_HOLDOFF 28'h000_0005
`define CAHC_RST_STAT_SIZE 16'h0001
`define CAHC_RST_BLOCKS 32'h0001_0001

// Timing
`define CAHC_CLK_NS 50
`define CAHC_ARM_STEP_NS 100
`define CAHC_HO_STEP_NS 10
`define CAHC_ARM_CYC_PER_STEP 28'd2
`define CAHC_HO_STEPS_PER_CYC 28'd5

`endif

// ==== cahc_sync.v ====
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are levels; the first stage feeds only the second.
`default_nettype none

module cahc_sync #(
    parameter W = 3
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Pins and their synchronised copy
    input wire [W-1:0] i_async,
    output reg [W-1:0] o_sync
);

reg [W-1:0] meta;

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        meta <= {W{1'b0}};
        o_sync <= {W{1'b0}};
    end else begin
        meta <= i_async;
        o_sync <= meta;
    end
end

endmodule // cahc_sync
`default_nettype wire

// ==== cahc_math.v ====
// Sequential unsigned divider (48/16) and integer square root (32 bits).
// Assumes one operation at a time; start is ignored while busy.
`default_nettype none

module cahc_math (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Request
    input wire i_start,
    input wire i_op_sqrt,
    input wire [47:0] i_num,
    input wire [15:0] i_den,
    // Answer
    output reg o_done,
    output reg [47:0] o_res
);

reg busy;
reg op_sqrt;
reg [5:0] step;
reg [47:0] quo;
reg [16:0] rem;
reg [15:0] den;
reg [31:0] sq_op;
reg [31:0] sq_res;
reg [31:0] sq_one;
wire [16:0] rem_sh = {rem[15:0], quo[47]};
wire [31:0] sq_try = sq_res + sq_one;

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        busy <= 1'b0;
        op_sqrt <= 1'b0;
        step <= 6'h00;
        quo <= 48'h0000_0000_0000;
        rem <= 17'h0_0000;
        den <= 16'h0000;
        sq_op <= 32'h0000_0000;
        sq_res <= 32'h0000_0000;
        sq_one <= 32'h0000_0000;
        o_done <= 1'b0;
        o_res <= 48'h0000_0000_0000;
    end else begin
        o_done <= 1'b0;
        if (!busy) begin
            if (i_start) begin
                busy <= 1'b1;
                op_sqrt <= i_op_sqrt;
                step <= i_op_sqrt ? 6'd16 : 6'd48;
                quo <= i_num;
                rem <= 17'h0_0000;
                den <= i_den;
                sq_op <= i_num[31:0];
                sq_res <= 32'h0000_0000;
                sq_one <= 32'h4000_0000;
            end
        end else if (op_sqrt) begin
            if (sq_op >= sq_try) begin
                sq_op <= sq_op - sq_try;
                sq_res <= (sq_res >> 1) + sq_one;
            end else begin
                sq_res <= sq_res >> 1;
            end
            sq_one <= sq_one >> 2;
            step <= step - 6'd1;
            if (step == 6'd1) begin
                busy <= 1'b0;
                o_done <= 1'b1;
                o_res <= {16'h0000, ((sq_op >= sq_try) ? ((sq_res >> 1) + sq_one) : (sq_res >> 1))};
            end
        end else begin
            // Restoring division, one quotient bit per cycle
            if (rem_sh >= {1'b0, den}) begin
                rem <= rem_sh - {1'b0, den};
                quo <= {quo[46:0], 1'b1};
            end else begin
                rem <= rem_sh;
                quo <= {quo[46:0], 1'b0};
            end
            step <= step - 6'd1;
            if (step == 6'd1) begin
                busy <= 1'b0;
                o_done <= 1'b1;
                o_res <= {quo[46:0], (rem_sh >= {1'b0, den})};
            end
        end
    end
end

endmodule // cahc_math
`default_nettype wire

// ==== cahc_asserts.sv ====
// Port checks for the arming and hold-off block.
// Assumes one APB master on the system clock.
`default_nettype none
module cahc_asserts (
    // Clock and reset
    input wire logic i_sys_clk, i_rst_n,
    // APB and control outputs
    input wire logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic o_trig, o_holdoff, o_ref_ext
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rdy_once; o_pready |=> !o_pready; endproperty
    a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
    property p_rdy_setup; i_psel && !i_penable |=> o_pready; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("ready late");
    property p_err_rdy; o_pslverr |-> o_pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    property p_wr_zero; o_pready && i_pwrite |-> o_prdata == 32'h0000_0000; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
    property p_err_zero; o_pslverr |-> o_prdata == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("read data on error");
    property p_trig_once; o_trig |=> !o_trig; endproperty
    a_trig_once: assert property (p_trig_once) else $error("trigger too long");
    // Held-off triggers must never reach the capture side
    property p_trig_held; o_holdoff |-> !o_trig; endproperty
    a_trig_held: assert property (p_trig_held) else $error("trigger in hold-off");
    property p_ref_wr; $changed(o_ref_ext) |-> $past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2); endproperty
    a_ref_wr: assert property (p_ref_wr) else $error("reference moved alone");
endmodule // cahc_asserts
bind cahc_top cahc_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .o_trig(o_trig), .o_holdoff(o_holdoff), .o_ref_ext(o_ref_ext));
`default_nettype wire

// ==== cahc_partner.sv ====
// Signal sources for the A, B and rear arming pins.
// Assumes the bench enables each source; lines idle low.
`default_nettype none
module cahc_partner (
    input wire logic i_clk, i_a_en, i_b_en, i_e_req,
    output logic o_in_a = 1'b0, o_in_b = 1'b0, o_in_e = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph = 3'h0;
    // Toggle every 8 cycles, so both trains have a 16 cycle period
    always @(posedge i_clk) begin
        ph <= ph + 3'h1;
        o_in_e <= i_e_req;
        if (ph == 3'h7) begin
            o_in_a <= o_in_a ^ i_a_en;
            o_in_b <= o_in_b ^ i_b_en;
        end
    end
endmodule // cahc_partner
`default_nettype wire

// ==== tb_counter_arming_holdoff_control.sv ====
// Self-checking bench for the arming and hold-off block.
// Assumes the partner drives pins A, B and E.
`default_nettype none
`include "cahc_defs.vh"
module tb_counter_arming_holdoff_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, mv = 0, a_en = 0, b_en = 0, e_req = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rdat, prdata;
    logic [15:0] mval = 16'h0000, sval;
    logic perr, prdy, slv, pb, trig, armed, ho, sv, rx, ia, ib, ie, pp;
    int n_mismatch = 0, num_checks = 0, n, nf;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] rv [5] = '{`CAHC_RST_MODE, `CAHC_RST_ARM_DLY, `CAHC_RST_HOLDOFF, `CAHC_RST_STAT_SIZE, `CAHC_RST_BLOCKS};
    logic [15:0] se [4] = '{16'h000F, 16'h0005, 16'h0014, 16'h000A};
    cahc_top DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(prdy), .o_prdata(prdata), .o_pslverr(slv),
        .i_in_a(ia), .i_in_b(ib), .i_in_e(ie), .i_meas_valid(mv), .i_meas_value(mval), .o_path_b(pb),
        .o_trig(trig), .o_armed(armed), .o_holdoff(ho), .o_stat_valid(sv), .o_stat_value(sval), .o_ref_ext(rx));
    cahc_partner u_src (.i_clk(clk), .i_a_en(a_en), .i_b_en(b_en), .i_e_req(e_req), .o_in_a(ia), .o_in_b(ib), .o_in_e(ie));
    initial forever #25 clk = ~clk;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rdat = prdata;
        perr = slv;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    // Waits for armed (0), trigger (1) or result (2); n holds the cycles taken
    task automatic wfor(input int s);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(s == 0 ? armed === 1'b1 : s == 1 ? trig === 1'b1 : sv === 1'b1) && n < 3000);
        if (n >= 3000) n_mismatch++;
    endtask
    task automatic meas(input logic [15:0] v);
        mv <= 1'b1;
        mval <= v;
        @(posedge clk);
        mv <= 1'b0;
        @(posedge clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            apb(0, ra[i], 0);
            chk("reset value", rv[i], rdat);
        end
        apb(0, 8'h20, 0);
        chk("unmapped error", 1, perr);
        apb(1, 8'h00, 32'hFFFF_FFFF);
        apb(0, 8'h00, 0);
        chk("mode mask", `CAHC_MODE_MASK, rdat);
        chk("external reference", 1, rx);
        $display("test registers done");
        a_en <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            apb(1, 8'h00, m);
            nf = 0;
            repeat (64) begin
                @(posedge clk);
                if (pb === 1'b1 && pp === 1'b0) nf++;
                pp = pb;
            end
            chk("path b rises", m * 4, nf);
        end
        $display("test shared input done");
        apb(1, 8'h10, 32'h0001_0003);
        apb(1, 8'h14, 1);
        wfor(0);
        for (int i = 1; i < 4; i++) begin
            meas(16'(i));
            chk("echo", {16'h0001, 16'(i)}, {15'h0000, sv, sval});
        end
        repeat (3) @(posedge clk);
        chk("block done", 0, armed);
        $display("test single block done");
        apb(1, 8'h0C, 2);
        for (int m = 1; m < 5; m++) begin
            apb(1, 8'h00, m << 8);
            apb(1, 8'h14, 1);
            wfor(0);
            meas(16'h000A);
            meas(16'h0014);
            wfor(2);
            chk("cluster result", se[m - 1], sval);
            apb(1, 8'h14, 2);
        end
        $display("test statistics done");
        apb(1, 8'h04, 3);
        apb(1, 8'h00, 32'h0000_002C);
        apb(1, 8'h14, 1);
        b_en <= 1'b1;
        nf = 0;
        do begin
            @(posedge clk);
            if (pp === 1'b1 && ib === 1'b0) nf++;
            pp = ib;
        end while (armed !== 1'b1 && nf < 20);
        chk("falling b edges", 4, nf);
        apb(1, 8'h14, 2);
        apb(1, 8'h04, 4);
        apb(1, 8'h00, 32'h0000_0012);
        apb(1, 8'h14, 1);
        repeat (40) @(posedge clk);
        chk("b ignored on rear", 0, armed);
        e_req <= 1'b1;
        @(posedge clk);
        e_req <= 1'b0;
        wfor(0);
        chk("time delay window", 1, n >= 8 && n <= 16);
        apb(1, 8'h14, 2);
        $display("test arming done");
        apb(1, 8'h08, 200);
        apb(1, 8'h10, 32'h0001_FFFF);
        for (int m = 0; m < 2; m++) begin
            apb(1, 8'h00, m << 6);
            apb(1, 8'h14, 1);
            wfor(1);
            wfor(1);
            chk("trigger spacing", m ? 48 : 16, n);
            @(posedge clk);
            chk("hold-off flag", m, ho);
            apb(1, 8'h14, 2);
        end
        $display("test hold-off done");
        summarize();
    end
endmodule // tb_counter_arming_holdoff_control
`default_nettype wire
